// File: src/mdc_cmem.sv
// common subbank words: pages, indexes and global reloads
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"
module mdc_cmem
  import mdc_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_we,
  input  wire logic [3:0] i_addr,
  input  wire mdc_word_t i_wdata,
  output mdc_word_t      o_rdata,
  output mdc_word_t      o_words [`MDC_NCOM]
);
  mdc_word_t mem_reg [`MDC_NCOM];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `MDC_NCOM; i++) begin
        mem_reg[i] <= 16'h0000;
      end
    end else if (i_we && i_addr < 4'(`MDC_NCOM)) begin
      mem_reg[i_addr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= (i_addr < 4'(`MDC_NCOM)) ? mem_reg[i_addr] : 16'h0000;
    end
  end

  assign o_words = mem_reg;
endmodule
`default_nettype wire

// File: src/mdc_consts.svh
// offsets, field positions and codes of the six-channel dma controller
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH
`define MDC_A_PREC   8'h54
`define MDC_A_PTR    8'h55
`define MDC_A_SDI    8'h56
`define MDC_A_SDN    8'h57
`define MDC_NCH      6
`define MDC_CH_WORDS 6'd30
`define MDC_NCOM     10
`define MDC_F_SRC    3'h0
`define MDC_F_DST    3'h1
`define MDC_F_CTR    3'h2
`define MDC_F_SFC    3'h3
`define MDC_F_MCR    3'h4
`define MDC_M_AUTO   15
`define MDC_M_INTERRUPT_MODE_BIT   14
`define MDC_M_IE     13
`define MDC_M_DW     12
`define MDC_M_ABU    11
`define MDC_M_SMOD   6
`define MDC_M_SSEL   5
`define MDC_M_DMOD   2
`define MDC_M_DSEL   1
`define MDC_P_RTE    14
`define MDC_P_HI     8
`define MDC_S_SYN    12
`define MDC_C_IDX0   2
`define MDC_C_FRI0   4
`define MDC_C_GSA    6
`define MDC_C_GDA    7
`define MDC_C_GCR    8
`define MDC_C_GFR    9
`define MDC_R_DEF    2'h0
`define MDC_R_HI23   2'h1
`define MDC_R_ALL    2'h2
`endif

// File: src/mdc_pkg.sv
// types of the six-channel dma controller
package mdc_pkg;
  typedef enum logic [1:0] {
    MDC_IDLE = 2'b00,
    MDC_RD   = 2'b01,
    MDC_WR   = 2'b11,
    MDC_UPD  = 2'b10
  } mdc_state_t;
  typedef enum logic [1:0] {
    MDC_AM_HOLD = 2'h0,
    MDC_AM_INC  = 2'h1,
    MDC_AM_DEC  = 2'h2,
    MDC_AM_IDX  = 2'h3
  } mdc_amode_t;
  typedef logic [15:0] mdc_word_t;
endpackage

// File: src/mdc_top.sv
// six-channel dma controller with subbank register access
`timescale 1ns/100ps
`default_nettype none
`include "mdc_consts.svh"
module mdc_top
  import mdc_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic [7:0] i_mmr_addr,
  input  wire logic       i_mmr_wr,
  input  wire logic       i_mmr_rd,
  input  wire mdc_word_t  i_mmr_wdata,
  output mdc_word_t       o_mmr_rdata,
  output logic            o_mmr_rvalid,
  output logic            o_mem_req,
  output logic            o_mem_we,
  output mdc_word_t       o_mem_addr,
  output mdc_word_t       o_mem_wdata,
  input  wire logic       i_mem_ack,
  input  wire mdc_word_t  i_mem_rdata,
  input  wire logic [6:0] i_evt,
  input  wire logic       i_timer1_int,
  input  wire logic       i_port1_rx_int,
  input  wire logic       i_port1_tx_int,
  output logic            o_int_line6,
  output logic            o_int_line7,
  output logic            o_int_line10,
  output logic            o_int_line11,
  output logic            o_int_line12,
  output logic            o_int_line13
);
  // ==========================================================
  // registers
  mdc_word_t  src_reg [`MDC_NCH];
  mdc_word_t  dst_reg [`MDC_NCH];
  mdc_word_t  ctr_reg [`MDC_NCH];
  mdc_word_t  sfc_reg [`MDC_NCH];
  mdc_word_t  mcr_reg [`MDC_NCH];
  mdc_word_t  ecnt_reg [`MDC_NCH];
  mdc_word_t  prec_reg;
  mdc_word_t  ptr_reg;
  mdc_word_t  chq_reg;
  mdc_word_t  cm_rdata;
  mdc_word_t  cm_words [`MDC_NCOM];
  mdc_state_t st_reg;
  logic [5:0] pend_reg;
  logic [5:0] irq_reg;
  logic [2:0] cur_reg;
  logic [2:0] rr_hi_reg;
  logic [2:0] rr_lo_reg;
  logic       half_reg;
  logic       rd1_reg;
  logic       rdcm_reg;

  // ==========================================================
  // subbank decode
  logic [5:0] sub;
  logic [2:0] sub_ch;
  logic [2:0] sub_f;
  logic       ch_area;
  logic       sb_acc;
  logic       sb_wr;
  logic       cm_we;
  assign sub     = ptr_reg[5:0];
  assign sub_ch  = 3'(sub / 6'd5);
  assign sub_f   = 3'(sub % 6'd5);
  assign ch_area = sub < `MDC_CH_WORDS;
  assign sb_acc  = i_mmr_addr == `MDC_A_SDI || i_mmr_addr == `MDC_A_SDN;
  assign sb_wr   = i_mmr_wr && sb_acc;
  assign cm_we   = sb_wr && !ch_area;

  mdc_cmem u_cmem (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_we      (cm_we),
    .i_addr    (4'(sub - `MDC_CH_WORDS)),
    .i_wdata   (i_mmr_wdata),
    .o_rdata   (cm_rdata),
    .o_words   (cm_words)
  );

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ptr_reg <= 16'h0000;
    end else if (i_mmr_wr && i_mmr_addr == `MDC_A_PTR) begin
      ptr_reg <= i_mmr_wdata;
    end else if ((i_mmr_wr || i_mmr_rd) && i_mmr_addr == `MDC_A_SDI) begin
      ptr_reg <= ptr_reg + 16'h0001;
    end
  end

  // ==========================================================
  // read path, two cycles
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chq_reg      <= 16'h0000;
      rd1_reg      <= 1'b0;
      rdcm_reg     <= 1'b0;
      o_mmr_rdata  <= 16'h0000;
      o_mmr_rvalid <= 1'b0;
    end else begin
      rd1_reg      <= i_mmr_rd;
      rdcm_reg     <= sb_acc && !ch_area;
      o_mmr_rvalid <= rd1_reg;
      o_mmr_rdata  <= rdcm_reg ? cm_rdata : chq_reg;
      chq_reg      <= 16'h0000;
      if (i_mmr_addr == `MDC_A_PREC) begin
        chq_reg <= prec_reg;
      end else if (i_mmr_addr == `MDC_A_PTR) begin
        chq_reg <= ptr_reg;
      end else if (sb_acc && ch_area) begin
        case (sub_f)
          `MDC_F_SRC: chq_reg <= src_reg[sub_ch];
          `MDC_F_DST: chq_reg <= dst_reg[sub_ch];
          `MDC_F_CTR: chq_reg <= ctr_reg[sub_ch];
          `MDC_F_SFC: chq_reg <= sfc_reg[sub_ch];
          default:    chq_reg <= mcr_reg[sub_ch];
        endcase
      end
    end
  end

  // ==========================================================
  // arbitration
  function automatic logic [3:0] pick(logic [5:0] m, logic [2:0] last);
    logic [3:0] r;
    logic [2:0] k;
    r = 4'h0;
    for (int i = 6; i >= 1; i--) begin
      k = 3'((int'(last) + i) % 6);
      if (m[k]) r = {1'b1, k};
    end
    return r;
  endfunction

  function automatic logic evt_hit(logic [3:0] code, logic [6:0] e);
    case (code)
      4'h1:    return e[0];
      4'h2:    return e[1];
      4'h5:    return e[2];
      4'h6:    return e[3];
      4'hd:    return e[4];
      4'he:    return e[5];
      4'hf:    return e[6];
      default: return 1'b0;
    endcase
  endfunction

  logic [5:0] req;
  logic [5:0] hi_req;
  logic [3:0] p_hi;
  logic [3:0] p_lo;
  logic [3:0] gnt;
  logic       start;
  for (genvar c = 0; c < `MDC_NCH; c++) begin : g_req
    assign req[c] = prec_reg[c] &&
      (sfc_reg[c][15:`MDC_S_SYN] == 4'h0 || pend_reg[c]);
  end
  assign hi_req = req & prec_reg[`MDC_P_HI +: 6];
  assign p_hi   = pick(hi_req, rr_hi_reg);
  assign p_lo   = pick(req & ~hi_req, rr_lo_reg);
  assign gnt    = p_hi[3] ? p_hi : p_lo;
  assign start  = st_reg == MDC_IDLE && gnt[3];

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pend_reg <= 6'h00;
    end else begin
      for (int c = 0; c < `MDC_NCH; c++) begin
        if (start && gnt[2:0] == 3'(c)) pend_reg[c] <= 1'b0;
        if (evt_hit(sfc_reg[c][15:`MDC_S_SYN], i_evt)) begin
          pend_reg[c] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // element update
  mdc_word_t  mcr;
  mdc_word_t  ctr_dec;
  logic       lastf;
  logic       lastb;
  logic       dw_first;
  logic       upd;
  logic       half_evt;
  logic       fire;
  assign mcr      = mcr_reg[cur_reg];
  assign lastf    = ctr_reg[cur_reg] == 16'h0000;
  assign lastb    = lastf && sfc_reg[cur_reg][7:0] == 8'h00;
  assign dw_first = mcr[`MDC_M_DW] && !half_reg;
  assign upd      = st_reg == MDC_UPD && !dw_first;
  assign ctr_dec  = ctr_reg[cur_reg] - 16'h0001;
  assign half_evt = !lastf && ctr_dec == {1'b0, ecnt_reg[cur_reg][15:1]};
  assign fire     = upd && mcr[`MDC_M_IE] && (lastb ||
    (mcr[`MDC_M_INTERRUPT_MODE_BIT] && (mcr[`MDC_M_ABU] ? half_evt : lastf)));

  // addresses go out as is; no processor mode bit enters here
  function automatic mdc_word_t adj(mdc_word_t a, logic [1:0] md,
                                    logic sel, logic lf, logic first);
    mdc_word_t step;
    step = lf ? cm_words[`MDC_C_FRI0 + int'(sel)]
              : cm_words[`MDC_C_IDX0 + int'(sel)];
    case (md)
      MDC_AM_HOLD: return a;
      MDC_AM_INC:  return a + 16'h0001;
      MDC_AM_DEC:  return a - 16'h0001;
      default:     return first ? a + 16'h0001 : a + step;
    endcase
  endfunction

  // ==========================================================
  // channel registers: engine update, cpu write last
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int c = 0; c < `MDC_NCH; c++) begin
        src_reg[c]  <= 16'h0000;
        dst_reg[c]  <= 16'h0000;
        ctr_reg[c]  <= 16'h0000;
        sfc_reg[c]  <= 16'h0000;
        mcr_reg[c]  <= 16'h0000;
        ecnt_reg[c] <= 16'h0000;
      end
    end else begin
      if (st_reg == MDC_UPD) begin
        src_reg[cur_reg] <= adj(src_reg[cur_reg],
          mcr[`MDC_M_SMOD +: 2], mcr[`MDC_M_SSEL], lastf, dw_first);
        dst_reg[cur_reg] <= adj(dst_reg[cur_reg],
          mcr[`MDC_M_DMOD +: 2], mcr[`MDC_M_DSEL], lastf, dw_first);
      end
      if (upd) begin
        if (lastb && mcr[`MDC_M_AUTO]) begin
          src_reg[cur_reg]       <= cm_words[`MDC_C_GSA];
          dst_reg[cur_reg]       <= cm_words[`MDC_C_GDA];
          ctr_reg[cur_reg]       <= cm_words[`MDC_C_GCR];
          ecnt_reg[cur_reg]      <= cm_words[`MDC_C_GCR];
          sfc_reg[cur_reg][7:0]  <= cm_words[`MDC_C_GFR][7:0];
        end else if (lastf) begin
          ctr_reg[cur_reg] <= ecnt_reg[cur_reg];
          if (!lastb) begin
            sfc_reg[cur_reg][7:0] <= sfc_reg[cur_reg][7:0] - 8'h01;
          end
        end else begin
          ctr_reg[cur_reg] <= ctr_dec;
        end
      end
      if (sb_wr && ch_area) begin
        case (sub_f)
          `MDC_F_SRC: src_reg[sub_ch] <= i_mmr_wdata;
          `MDC_F_DST: dst_reg[sub_ch] <= i_mmr_wdata;
          `MDC_F_CTR: begin
            ctr_reg[sub_ch]  <= i_mmr_wdata;
            ecnt_reg[sub_ch] <= i_mmr_wdata;
          end
          `MDC_F_SFC: sfc_reg[sub_ch] <= i_mmr_wdata;
          default:    mcr_reg[sub_ch] <= i_mmr_wdata;
        endcase
      end
    end
  end

  // priority/enable: block end without reload or autobuffer disables
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prec_reg <= 16'h0000;
    end else if (i_mmr_wr && i_mmr_addr == `MDC_A_PREC) begin
      prec_reg <= i_mmr_wdata;
    end else if (upd && lastb && !mcr[`MDC_M_AUTO] && !mcr[`MDC_M_ABU]) begin
      prec_reg[cur_reg] <= 1'b0;
    end
  end

  // ==========================================================
  // transfer engine
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg      <= MDC_IDLE;
      cur_reg     <= 3'h0;
      half_reg    <= 1'b0;
      rr_hi_reg   <= 3'h5;
      rr_lo_reg   <= 3'h5;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 16'h0000;
    end else begin
      case (st_reg)
        MDC_IDLE: begin
          if (start) begin
            cur_reg <= gnt[2:0];
            st_reg  <= MDC_RD;
            if (p_hi[3]) rr_hi_reg <= gnt[2:0];
            else rr_lo_reg <= gnt[2:0];
          end
        end
        MDC_RD: begin
          if (!o_mem_req) begin
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b0;
            o_mem_addr <= src_reg[cur_reg];
          end else if (i_mem_ack) begin
            o_mem_req   <= 1'b0;
            o_mem_wdata <= i_mem_rdata;
            st_reg      <= MDC_WR;
          end
        end
        MDC_WR: begin
          if (!o_mem_req) begin
            o_mem_req  <= 1'b1;
            o_mem_we   <= 1'b1;
            o_mem_addr <= dst_reg[cur_reg];
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we  <= 1'b0;
            st_reg    <= MDC_UPD;
          end
        end
        MDC_UPD: begin
          half_reg <= dw_first;
          st_reg   <= dw_first ? MDC_RD : MDC_IDLE;
        end
        default: st_reg <= MDC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // interrupts and routing onto shared lines
  logic [1:0] rte;
  logic       dma23;
  assign rte   = prec_reg[`MDC_P_RTE +: 2];
  assign dma23 = rte == `MDC_R_HI23 || rte == `MDC_R_ALL;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      irq_reg      <= 6'h00;
      o_int_line6  <= 1'b0;
      o_int_line7  <= 1'b0;
      o_int_line10 <= 1'b0;
      o_int_line11 <= 1'b0;
      o_int_line12 <= 1'b0;
      o_int_line13 <= 1'b0;
    end else begin
      irq_reg      <= fire ? 6'(1 << cur_reg) : 6'h00;
      o_int_line6  <= rte == `MDC_R_ALL && irq_reg[0];
      o_int_line7  <= rte == `MDC_R_ALL ? irq_reg[1] : i_timer1_int;
      o_int_line10 <= dma23 ? irq_reg[2] : i_port1_rx_int;
      o_int_line11 <= dma23 ? irq_reg[3] : i_port1_tx_int;
      o_int_line12 <= irq_reg[4];
      o_int_line13 <= irq_reg[5];
    end
  end

  // ==========================================================
  // checks
  property p_hi_first;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      start && hi_req != 6'h00 |=> prec_reg[`MDC_P_HI + int'(cur_reg)];
  endproperty
  a_hi_first: assert property (p_hi_first)
    else $error("low channel served over high");

  property p_autoinc;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_mmr_wr && i_mmr_addr == `MDC_A_SDI |=>
        ptr_reg == $past(ptr_reg) + 16'h0001;
  endproperty
  a_autoinc: assert property (p_autoinc)
    else $error("subbank pointer not incremented");

  property p_plain;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      i_mmr_wr && i_mmr_addr == `MDC_A_SDN |=> $stable(ptr_reg);
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain data port moved pointer");

  property p_ctr_dec;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      upd && !lastf && !sb_wr |=> ctr_reg[$past(cur_reg)] == $past(ctr_dec);
  endproperty
  a_ctr_dec: assert property (p_ctr_dec)
    else $error("element counter not decremented");

  property p_reload;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      upd && lastb && mcr[`MDC_M_AUTO] && !sb_wr |=>
        src_reg[$past(cur_reg)] == cm_words[`MDC_C_GSA];
  endproperty
  a_reload: assert property (p_reload)
    else $error("source not reloaded at block end");

  property p_no_ie;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      upd && !mcr[`MDC_M_IE] |=> irq_reg == 6'h00 ##1 !o_int_line12;
  endproperty
  a_no_ie: assert property (p_no_ie)
    else $error("interrupt with enable clear");

  property p_route_def;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      rte == `MDC_R_DEF |=> o_int_line10 == $past(i_port1_rx_int) &&
        o_int_line11 == $past(i_port1_tx_int) && !o_int_line6;
  endproperty
  a_route_def: assert property (p_route_def)
    else $error("default routing broken");

  property p_sync;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      start && sfc_reg[gnt[2:0]][15:`MDC_S_SYN] != 4'h0 |->
        pend_reg[gnt[2:0]] ##1 st_reg == MDC_RD;
  endproperty
  a_sync: assert property (p_sync)
    else $error("synced channel started without event");
endmodule
`default_nettype wire

// File: verif/mdc_mem_model.sv
// memory and peripheral partner answering the dma memory link
`timescale 1ns/100ps
`default_nettype none
module mdc_mem_model
  import mdc_pkg::*;
(
  input  wire logic      i_ref_clk,
  input  wire logic      i_sys_rst,
  input  wire logic      i_slow,
  input  wire logic      i_mem_req,
  input  wire logic      i_mem_we,
  input  wire mdc_word_t i_mem_addr,
  output logic           o_mem_ack,
  output mdc_word_t      o_mem_rdata
);
  logic [1:0] wait_cnt;
  logic       done;
  // ==========
  // one ack per request, after zero or three idle cycles
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wait_cnt    <= 2'h0;
      done        <= 1'b0;
      o_mem_ack   <= 1'b0;
      o_mem_rdata <= 16'h0000;
    end else begin
      o_mem_ack   <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
      if (!i_mem_req) begin
        wait_cnt <= 2'h0;
        done     <= 1'b0;
      end else if (!done && (!i_slow || wait_cnt == 2'h3)) begin
        o_mem_ack   <= 1'b1;
        done        <= 1'b1;
        o_mem_rdata <= i_mem_we ? ~i_mem_addr : i_mem_addr ^ 16'hc3a0;
      end else if (!done) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the six-channel dma controller
`timescale 1ns/100ps
`default_nettype none
module tb
  import mdc_pkg::*;
;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] mmr_addr = 8'h00;
  logic       mmr_wr = 1'b0;
  logic       mmr_rd = 1'b0;
  mdc_word_t  mmr_wdata = 16'h0000;
  logic [6:0] evt = 7'h00;
  logic       tmr1 = 1'b0;
  logic       p1rx = 1'b0;
  logic       p1tx = 1'b0;
  logic       slow = 1'b0;
  mdc_word_t  mmr_rdata, mem_addr, mem_wdata, mem_rdata;
  logic       mmr_rvalid, mem_req, mem_we, mem_ack;
  logic       ln6, ln7, ln10, ln11, ln12, ln13;
  int         num_errors = 0;
  int         compares = 0;
  int         n10 = 0;
  int         n12 = 0;
  int         n6 = 0;
  int         n13 = 0;
  mdc_word_t  wa[$];
  mdc_word_t  wd[$];
  mdc_word_t  im[3] = '{16'h6000, 16'h2000, 16'h4000};
  int         np[3] = '{2, 1, 0};
  mdc_word_t  pd[6] = '{16'h0600, 16'h0600, 16'h0400, 16'h0500,
                        16'h0400, 16'h0500};
  mdc_word_t  ad[3] = '{16'h0780, 16'h0790, 16'h07a0};
  mdc_word_t  as[3] = '{16'h0700, 16'h0710, 16'h0720};
  logic [3:0] sc[7] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'hd, 4'he, 4'hf};
  // ==========
  // design and partner
  mdc_top mdc_top_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_mmr_addr(mmr_addr), .i_mmr_wr(mmr_wr), .i_mmr_rd(mmr_rd),
    .i_mmr_wdata(mmr_wdata), .o_mmr_rdata(mmr_rdata),
    .o_mmr_rvalid(mmr_rvalid), .o_mem_req(mem_req), .o_mem_we(mem_we),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .i_evt(evt), .i_timer1_int(tmr1),
    .i_port1_rx_int(p1rx), .i_port1_tx_int(p1tx), .o_int_line6(ln6),
    .o_int_line7(ln7), .o_int_line10(ln10), .o_int_line11(ln11),
    .o_int_line12(ln12), .o_int_line13(ln13));
  mdc_mem_model mdc_mem_model_i (.i_ref_clk(ref_clk), .i_sys_rst(sys_rst),
    .i_slow(slow), .i_mem_req(mem_req), .i_mem_we(mem_we),
    .i_mem_addr(mem_addr), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));
  always #2.5 ref_clk = ~ref_clk;
  // ==========
  // monitor of completed writes and interrupt pulses
  always @(posedge ref_clk) begin
    if (mem_req && mem_we && mem_ack) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_wdata);
    end
    if (ln10) n10++;
    if (ln12) n12++;
    if (ln6) n6++;
    if (ln13) n13++;
  end
  // ==========
  // tasks
  task automatic final_report;
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input mdc_word_t seen, input mdc_word_t exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input mdc_word_t v);
    mmr_addr = a;
    mmr_wr = w;
    mmr_rd = !w;
    mmr_wdata = v;
    tick(1);
    mmr_wr = 1'b0;
    mmr_rd = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input mdc_word_t exp);
    acc(a, 1'b0, 16'h0000);
    chk({15'h0, mmr_rvalid}, 16'h0001);
    chk(mmr_rdata, exp);
  endtask
  task automatic cfg(input int ch, input mdc_word_t s, dd, c, f, m);
    acc(8'h55, 1'b1, 16'(ch * 5));
    acc(8'h56, 1'b1, s);
    acc(8'h56, 1'b1, dd);
    acc(8'h56, 1'b1, c);
    acc(8'h56, 1'b1, f);
    acc(8'h56, 1'b1, m);
  endtask
  task automatic wait_wr(input int n);
    int k = 0;
    while (wa.size() < n && k < 3000) begin
      tick(1);
      k++;
    end
    tick(6);
  endtask
  task automatic clr;
    wa.delete();
    wd.delete();
    n10 = 0;
    n12 = 0;
    n6 = 0;
    n13 = 0;
  endtask
  // ==========
  // watchdog
  initial begin
    #150000;
    num_errors++;
    final_report();
  end
  // ==========
  // tests
  initial begin
    mdc_word_t s, dd;
    tick(2);
    sys_rst = 1'b0;
    // subbank access
    rd(8'h54, 16'h0000);
    acc(8'h55, 1'b1, 16'h0000);
    acc(8'h56, 1'b1, 16'h1234);
    acc(8'h56, 1'b1, 16'h5678);
    rd(8'h55, 16'h0002);
    acc(8'h55, 1'b1, 16'h0001);
    rd(8'h57, 16'h5678);
    rd(8'h57, 16'h5678);
    rd(8'h55, 16'h0001);
    acc(8'h55, 1'b1, 16'h0028);
    acc(8'h57, 1'b1, 16'hffff);
    rd(8'h57, 16'h0000);
    rd(8'h60, 16'h0000);
    // indexed frames and interrupt modes
    acc(8'h55, 1'b1, 16'h0021);
    acc(8'h56, 1'b1, 16'h0003);
    acc(8'h56, 1'b1, 16'h0000);
    acc(8'h56, 1'b1, 16'h0010);
    for (int i = 0; i < 3; i++) begin
      clr();
      cfg(4, 16'h0100, 16'h0200, 16'h0002, 16'h0001, 16'h004e | im[i]);
      acc(8'h54, 1'b1, 16'h0010);
      wait_wr(6);
      s = 16'h0100;
      dd = 16'h0200;
      chk(16'(wa.size()), 16'h0006);
      for (int k = 0; k < 6; k++) begin
        chk(wa[k], dd);
        chk(wd[k], s ^ 16'hc3a0);
        dd = dd + ((k % 3 == 2) ? 16'h0010 : 16'h0003);
        s = s + 16'h0001;
      end
      chk(16'(n12), 16'(np[i]));
      rd(8'h54, 16'h0000);
    end
    // doubleword
    clr();
    cfg(5, 16'h0100, 16'h0300, 16'h0001, 16'h0000, 16'h3044);
    acc(8'h54, 1'b1, 16'h0020);
    wait_wr(4);
    chk(16'(wa.size()), 16'h0004);
    chk(16'(n13), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      chk(wa[k], 16'h0300 + 16'(k));
      chk(wd[k], (16'h0100 + 16'(k)) ^ 16'hc3a0);
    end
    // priority levels
    clr();
    cfg(0, 16'h0010, 16'h0400, 16'h0001, 16'h0000, 16'h0040);
    cfg(1, 16'h0020, 16'h0500, 16'h0001, 16'h0000, 16'h0040);
    cfg(2, 16'h0030, 16'h0600, 16'h0001, 16'h0000, 16'h2040);
    acc(8'h54, 1'b1, 16'h4407);
    wait_wr(6);
    for (int k = 0; k < 6; k++) chk(wa[k], pd[k]);
    chk(16'(n10), 16'h0001);
    // auto_reload_enable with reloads changed mid-block
    clr();
    slow = 1'b1;
    acc(8'h55, 1'b1, 16'h0024);
    acc(8'h56, 1'b1, 16'h0710);
    acc(8'h56, 1'b1, 16'h0790);
    acc(8'h56, 1'b1, 16'h0000);
    acc(8'h56, 1'b1, 16'h0000);
    cfg(1, 16'h0700, 16'h0780, 16'h0000, 16'h0000, 16'h8040);
    acc(8'h54, 1'b1, 16'h0002);
    wait_wr(1);
    acc(8'h55, 1'b1, 16'h0024);
    acc(8'h56, 1'b1, 16'h0720);
    acc(8'h56, 1'b1, 16'h07a0);
    wait_wr(3);
    acc(8'h54, 1'b1, 16'h0000);
    tick(20);
    slow = 1'b0;
    for (int k = 0; k < 3; k++) begin
      chk(wa[k], ad[k]);
      chk(wd[k], as[k] ^ 16'hc3a0);
    end
    // sync events
    for (int k = 0; k < 7; k++) begin
      clr();
      cfg(3, 16'h0800, 16'h0900, 16'h0000, {sc[k], 12'h000}, 16'h0000);
      acc(8'h54, 1'b1, 16'h0008);
      evt = ~(7'h01 << k);
      tick(1);
      evt = 7'h00;
      tick(12);
      chk(16'(wa.size()), 16'h0000);
      evt = 7'h01 << k;
      tick(1);
      evt = 7'h00;
      wait_wr(1);
      chk(wa[0], 16'h0900);
    end
    // autobuffer: half and full interrupts, decrementing source
    clr();
    cfg(0, 16'h0a00, 16'h0b00, 16'h0003, 16'h0000, 16'h6880);
    acc(8'h54, 1'b1, 16'h8001);
    wait_wr(4);
    chk(16'(n6), 16'h0002);
    rd(8'h54, 16'h8001);
    acc(8'h54, 1'b1, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      chk(wa[k], 16'h0b00);
      chk(wd[k], (16'h0a00 - 16'(k)) ^ 16'hc3a0);
    end
    // shared interrupt lines
    for (int k = 0; k < 3; k++) begin
      acc(8'h54, 1'b1, {2'(k), 14'h0000});
      tmr1 = 1'b1;
      p1rx = 1'b1;
      p1tx = 1'b1;
      tick(3);
      chk({15'h0, ln7}, {15'h0, k != 2});
      chk({15'h0, ln10}, {15'h0, k == 0});
      chk({15'h0, ln11}, {15'h0, k == 0});
      chk({15'h0, ln6}, 16'h0000);
      tmr1 = 1'b0;
      p1rx = 1'b0;
      p1tx = 1'b0;
      tick(2);
    end
    final_report();
  end
endmodule
`default_nettype wire
